// *** inc/bridge_misc_pkg.sv ***
// Constants shared by the bridge miscellaneous configuration register bank
package bridge_misc_pkg;
	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam int unsigned IDX_MISC_STATUS = 'h6a;
	localparam int unsigned IDX_FAST_DMA0 = 'h76;
	localparam int unsigned IDX_FAST_DMA1 = 'h77;
	localparam int unsigned IDX_IOAPIC_BASE = 'h80;
	localparam int unsigned IDX_IRQ_STATUS = 'ha0;
	localparam int unsigned IDX_IRQ_MASK = 'ha1;
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] ADDR_MISC_STATUS = ADDR_W'(IDX_MISC_STATUS * 4);
	localparam logic [ADDR_W-1:0] ADDR_FAST_DMA0 = ADDR_W'(IDX_FAST_DMA0 * 4);
	localparam logic [ADDR_W-1:0] ADDR_FAST_DMA1 = ADDR_W'(IDX_FAST_DMA1 * 4);
	localparam logic [ADDR_W-1:0] ADDR_IOAPIC_BASE = ADDR_W'(IDX_IOAPIC_BASE * 4);
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = ADDR_W'(IDX_IRQ_STATUS * 4);
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = ADDR_W'(IDX_IRQ_MASK * 4);

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int SERR_TIMEOUT_BIT = 15;
	localparam int RETRY_EN_BIT = 7;
	localparam int FAST_EN_BIT = 7;
	localparam int A12_MASK_BIT = 6;
	localparam logic [15:0] MISC_RST = 16'h0000;
	localparam logic [7:0] FAST_DMA_RST = 8'h04;
	localparam logic [7:0] FAST_DMA_WMASK = 8'h87;
	localparam logic [7:0] FAST_DMA_ONES = 8'h08;
	localparam logic [7:0] IOAPIC_RST = 8'h00;
	localparam logic [7:0] IOAPIC_WMASK = 8'h7f;
	localparam logic [2:0] CHAN_DISABLED = 3'h4;
	localparam logic [15:0] IOAPIC_WINDOW_HI = 16'hfec0;

	// ------------------------------------------------------------
	// Interrupt sources
	// ------------------------------------------------------------
	localparam int IRQ_W = 2;
	localparam int IRQ_DISCARD = 0;
	localparam int IRQ_RETRY = 1;
	localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

	// ------------------------------------------------------------
	// Timing (in PCI clocks)
	// ------------------------------------------------------------
	localparam int unsigned DISCARD_CLOCKS_DEF = 2 ** 15;
	localparam logic [31:0] CNT_RST = 32'h0000_0000;
endpackage : bridge_misc_pkg

// *** design/bridge_misc_config_regs.sv ***
// Miscellaneous bridge configuration registers with APB access
// Function
// - Discard-timeout SERR sets status bit 15
// - Write one clears bit 15, zero keeps
// - Retry enable retries unlocked processor cycles
// - Only without pending delayed transaction, passive release
// - Retry disabled: processor cycles accepted normally
// - Two selectors pick fast type F channels
// - Bit 7 enables type F for chosen channel
// - Codes 0-3, 5-7 channels; 100 disabled
// - Selector bit 3 always reads one
// - Chip select matches address 15:12 to bits 5:2
// - Address 11:10 matches bits 1:0
// - Mask bit set ignores address bit 12
// - Mask bit clear compares address bit 12
// - Reset value selects base window locations
// - Discard timer expires after 2^15 idle clocks
//
// Added by the designer: the APB interface to the registers.
module bridge_misc_config_regs
	import bridge_misc_pkg::*;
#(
	parameter int unsigned DISCARD_CLOCKS = DISCARD_CLOCKS_DEF
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic dt_enable,
	input wire logic serr_on_timeout_enable,
	input wire logic dt_pending,
	input wire logic dt_retried,
	input wire logic passive_release_active,
	input wire logic cpu_cycle_valid,
	input wire logic cpu_cycle_locked,
	output logic cpu_retry_no_dt,
	output logic cpu_accept_normal,
	output logic dt_discard,
	output logic serr_req,
	output logic [7:0] fast_dma_chan_en,
	input wire logic pci_mem_valid,
	input wire logic [31:0] pci_addr,
	output logic ioapic_chip_select_n,
	output logic irq
);

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] chan_onehot(input logic [7:0] sel);
		logic [7:0] oh;
		oh = 8'h00;
		if (sel[FAST_EN_BIT] && sel[2:0] != CHAN_DISABLED) begin
			oh[sel[2:0]] = 1'b1;
		end
		return oh;
	endfunction : chan_onehot

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic serr_flag_q, serr_flag_d;
	logic retry_en_q;
	logic [7:0] dma0_q, dma1_q, apic_q;
	logic [IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q;
	logic [31:0] prdata_q;
	logic [31:0] cnt_q;
	logic expired_q;
	logic serr_req_q, dt_discard_q, retry_q, accept_q;
	logic [7:0] chan_en_q;
	logic cs_n_q;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire hit_misc = paddr == ADDR_MISC_STATUS;
	wire hit_dma0 = paddr == ADDR_FAST_DMA0;
	wire hit_dma1 = paddr == ADDR_FAST_DMA1;
	wire hit_apic = paddr == ADDR_IOAPIC_BASE;
	wire hit_ist = paddr == ADDR_IRQ_STATUS;
	wire hit_imask = paddr == ADDR_IRQ_MASK;
	wire mapped = hit_misc | hit_dma0 | hit_dma1 | hit_apic | hit_ist | hit_imask;
	wire wr = access && pwrite && mapped;
	wire wr_lo = wr && pstrb[0];
	wire wr_hi = wr && pstrb[1];
	wire rd_ist = access && !pwrite && hit_ist;

	// Reserved bits are simply never stored
	wire [15:0] misc_rd = {serr_flag_q, 7'h00, retry_en_q, 7'h00};
	wire [31:0] rd_word =
		hit_misc ? {16'h0000, misc_rd} :
		hit_dma0 ? {24'h000000, dma0_q | FAST_DMA_ONES} :
		hit_dma1 ? {24'h000000, dma1_q | FAST_DMA_ONES} :
		hit_apic ? {24'h000000, apic_q} :
		hit_ist ? {30'h0, irq_stat_q} :
		hit_imask ? {30'h0, irq_mask_q} : 32'h0000_0000;

	// One wait-free access phase; read data sampled at the setup edge
	assign pready = access;
	assign pslverr = access && !mapped;
	assign prdata = prdata_q;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
		end
	end

	// ------------------------------------------------------------
	// Discard timer
	// ------------------------------------------------------------
	// Counts clocks since the master last retried; one pulse per stale transaction
	wire timing = dt_enable && dt_pending && !dt_retried && !expired_q;
	wire expire = timing && cnt_q == DISCARD_CLOCKS;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= CNT_RST;
			expired_q <= 1'b0;
		end else begin
			cnt_q <= timing ? cnt_q + 32'h1 : CNT_RST;
			expired_q <= dt_pending && !dt_retried && (expired_q || expire);
		end
	end

	// ------------------------------------------------------------
	// Miscellaneous status and control
	// ------------------------------------------------------------
	wire serr_set = expire && serr_on_timeout_enable;
	wire serr_w1c = wr_hi && hit_misc && pwdata[SERR_TIMEOUT_BIT];
	// A timeout in the clearing cycle still leaves the flag set
	assign serr_flag_d = (serr_flag_q && !serr_w1c) || serr_set;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			serr_flag_q <= MISC_RST[SERR_TIMEOUT_BIT];
			retry_en_q <= MISC_RST[RETRY_EN_BIT];
		end else begin
			serr_flag_q <= serr_flag_d;
			if (wr_lo && hit_misc) begin
				retry_en_q <= pwdata[RETRY_EN_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// Processor cycle retry
	// ------------------------------------------------------------
	// Retry enable is trusted only with no delayed transaction pending and passive release on
	wire retry_now = cpu_cycle_valid && !cpu_cycle_locked && retry_en_q
		&& !dt_pending && passive_release_active;
	wire accept_now = cpu_cycle_valid && !retry_now;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			retry_q <= 1'b0;
			accept_q <= 1'b0;
			serr_req_q <= 1'b0;
			dt_discard_q <= 1'b0;
		end else begin
			retry_q <= retry_now;
			accept_q <= accept_now;
			serr_req_q <= serr_set;
			dt_discard_q <= expire;
		end
	end

	assign cpu_retry_no_dt = retry_q;
	assign cpu_accept_normal = accept_q;
	assign serr_req = serr_req_q;
	assign dt_discard = dt_discard_q;

	// ------------------------------------------------------------
	// Fast type F DMA selectors
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dma0_q <= FAST_DMA_RST;
			dma1_q <= FAST_DMA_RST;
		end else begin
			if (wr_lo && hit_dma0) begin
				dma0_q <= pwdata[7:0] & FAST_DMA_WMASK;
			end
			if (wr_lo && hit_dma1) begin
				dma1_q <= pwdata[7:0] & FAST_DMA_WMASK;
			end
		end
	end

	// Each selector names one channel; both may name the same one
	wire [7:0] chan_sel0 = chan_onehot(dma0_q);
	wire [7:0] chan_sel1 = chan_onehot(dma1_q);

	genvar ch;
	generate
		for (ch = 0; ch < 8; ch++) begin : g_chan
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					chan_en_q[ch] <= 1'b0;
				end else begin
					chan_en_q[ch] <= chan_sel0[ch] | chan_sel1[ch];
				end
			end
		end
	endgenerate

	assign fast_dma_chan_en = chan_en_q;

	// ------------------------------------------------------------
	// I/O APIC chip select
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			apic_q <= IOAPIC_RST;
		end else if (wr_lo && hit_apic) begin
			apic_q <= pwdata[7:0] & IOAPIC_WMASK;
		end
	end

	wire win_hit = pci_addr[31:16] == IOAPIC_WINDOW_HI && pci_addr[9:5] == 5'h00;
	wire x_hi_hit = pci_addr[15:13] == apic_q[5:3];
	wire a12_hit = apic_q[A12_MASK_BIT] || pci_addr[12] == apic_q[2];
	wire y_hit = pci_addr[11:10] == apic_q[1:0];
	// Two ranges share the select when masked; board logic splits them
	wire cs_hit = pci_mem_valid && win_hit && x_hi_hit && a12_hit && y_hit;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cs_n_q <= 1'b1;
		end else begin
			cs_n_q <= !cs_hit;
		end
	end

	assign ioapic_chip_select_n = cs_n_q;

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	wire [IRQ_W-1:0] irq_set = {retry_now, expire};
	// Only bits that were returned to software are cleared by the read
	wire [IRQ_W-1:0] irq_clr = rd_ist ? prdata_q[IRQ_W-1:0] : IRQ_RST;
	assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			irq_stat_q <= IRQ_RST;
			irq_mask_q <= IRQ_RST;
		end else begin
			irq_stat_q <= irq_stat_d;
			if (wr_lo && hit_imask) begin
				irq_mask_q <= pwdata[IRQ_W-1:0];
			end
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	serr_flag_set_a: assert property (serr_req |-> serr_flag_q)
		else $error("status flag missing after system error");
	serr_flag_clr_a: assert property (serr_w1c && !serr_set |=> !serr_flag_q)
		else $error("write one did not clear status flag");
	serr_flag_hold_a: assert property (
		wr_hi && hit_misc && !pwdata[SERR_TIMEOUT_BIT] && serr_flag_q |=> serr_flag_q)
		else $error("write zero cleared status flag");
	retry_issue_a: assert property (
		cpu_cycle_valid && !cpu_cycle_locked && retry_en_q && !dt_pending
		&& passive_release_active |=> cpu_retry_no_dt && !cpu_accept_normal)
		else $error("processor cycle not retried");
	retry_gate_a: assert property (
		cpu_retry_no_dt |-> !$past(dt_pending) && $past(passive_release_active))
		else $error("retry issued outside its conditions");
	accept_normal_a: assert property (
		cpu_cycle_valid && !retry_en_q |=> cpu_accept_normal && !cpu_retry_no_dt)
		else $error("processor cycle not accepted");
	dma_chan_a: assert property (
		dma0_q[FAST_EN_BIT] && dma0_q[2:0] == 3'h5 |=> fast_dma_chan_en[5])
		else $error("selected fast channel not enabled");
	dma_disabled_a: assert property (fast_dma_chan_en[4] == 1'b0)
		else $error("code 100 enabled a channel");
	dma_one_a: assert property (
		setup && !pwrite && (hit_dma0 || hit_dma1) |=> prdata[3] && prdata[6:4] == 3'h0)
		else $error("selector reserved bits read wrong");
	apic_default_a: assert property (
		apic_q == 8'h00 && pci_mem_valid && pci_addr == 32'hfec0_0010 |=> !ioapic_chip_select_n)
		else $error("base window not selected");
	apic_mask_a: assert property (
		apic_q == 8'h40 && pci_mem_valid && pci_addr == 32'hfec0_1000 |=> !ioapic_chip_select_n)
		else $error("masked bit 12 not ignored");
	apic_nomask_a: assert property (
		apic_q == 8'h00 && pci_mem_valid && pci_addr == 32'hfec0_1000 |=> ioapic_chip_select_n)
		else $error("bit 12 not compared");
	discard_quiet_a: assert property (
		dt_retried |=> !dt_discard [*8])
		else $error("discard too soon after retry");
	misc_rsv_a: assert property (
		setup && !pwrite && hit_misc |=> prdata[14:8] == 7'h00 && prdata[6:0] == 7'h00)
		else $error("reserved status bits not zero");

	serr_seen_c: cover property (serr_req ##1 serr_flag_q);
	retry_seen_c: cover property (cpu_retry_no_dt);
	cs_seen_c: cover property (!ioapic_chip_select_n);
	irq_seen_c: cover property ($rose(irq));

endmodule : bridge_misc_config_regs

// *** tb/bridge_misc_config_regs_tb.sv ***
// Self-checking testbench for the bridge miscellaneous configuration registers
module bridge_misc_config_regs_tb
	import bridge_misc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Signals and bookkeeping
	// ------------------------------------------------------------
	localparam int unsigned DCLK = 20;
	logic clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, pci_addr = '0, prdata, rnd, base;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, cpu_retry_no_dt, cpu_accept_normal, dt_discard, serr_req, irq;
	logic dt_enable = 0, serr_on_timeout_enable = 0, dt_pending = 0, dt_retried = 0;
	logic passive_release_active = 0, cpu_cycle_valid = 0, cpu_cycle_locked = 0;
	logic pci_mem_valid = 0, ioapic_chip_select_n;
	logic [7:0] fast_dma_chan_en, exp, r;
	logic [32:0] rd_q[$], cpu_q[$];
	integer seed = 32'haf1e09c6;
	int n_mismatch = 0, check_count = 0, cyc = 0;

	always #25 clk_sys = ~clk_sys;

	bridge_misc_config_regs #(.DISCARD_CLOCKS(DCLK)) u_dut (.clk_sys(clk_sys), .nrst(nrst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dt_enable(dt_enable), .serr_on_timeout_enable(serr_on_timeout_enable),
		.dt_pending(dt_pending), .dt_retried(dt_retried),
		.passive_release_active(passive_release_active), .cpu_cycle_valid(cpu_cycle_valid),
		.cpu_cycle_locked(cpu_cycle_locked), .cpu_retry_no_dt(cpu_retry_no_dt),
		.cpu_accept_normal(cpu_accept_normal), .dt_discard(dt_discard), .serr_req(serr_req),
		.fast_dma_chan_en(fast_dma_chan_en), .pci_mem_valid(pci_mem_valid), .pci_addr(pci_addr),
		.ioapic_chip_select_n(ioapic_chip_select_n), .irq(irq));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [32:0] seen, input logic [32:0] want);
		check_count++;
		if (seen !== want) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask : check

	task summarize;
		if (n_mismatch == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	task cycles(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cycles

	// Idle cycle after each transfer keeps one assignment per signal per step
	task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk_sys);
		penable <= 1;
		@(posedge clk_sys);
		while (pready !== 1'b1)
			@(posedge clk_sys);
		psel <= 0;
		penable <= 0;
		@(posedge clk_sys);
	endtask : apb

	task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		apb(1, a, d, 4'hf);
	endtask : wr

	task rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic err);
		rd_q.push_back({err, d});
		apb(0, a, $random(seed), 4'hf);
	endtask : rd

	task cpu(input logic lk, input logic pend, input logic pra, input logic ren);
		logic hit;
		hit = !lk && ren && !pend && pra;
		cpu_q.push_back({31'h0, hit, !hit});
		cpu_cycle_valid <= 1;
		cpu_cycle_locked <= lk;
		dt_pending <= pend;
		passive_release_active <= pra;
		@(posedge clk_sys);
	endtask : cpu

	task probe(input logic [31:0] a);
		logic hit;
		hit = a[31:16] == IOAPIC_WINDOW_HI && a[9:5] == 5'h0 && a[15:13] == r[5:3]
			&& (r[6] || a[12] == r[2]) && a[11:10] == r[1:0];
		pci_mem_valid <= 1;
		pci_addr <= a;
		@(posedge clk_sys);
		pci_mem_valid <= 0;
		pci_addr <= $random(seed);
		#1 check("apic select", ioapic_chip_select_n, !hit);
	endtask : probe

	task discard(input logic serr_en);
		int n, extra;
		serr_on_timeout_enable <= serr_en;
		dt_enable <= 1;
		dt_pending <= 1;
		n = 0;
		extra = 0;
		do begin
			@(posedge clk_sys);
			#1 n++;
		end while (dt_discard !== 1'b1 && n < 100);
		check("discard delay", 33'(n), 33'(DCLK + 1));
		check("serr", serr_req, serr_en);
		repeat (DCLK + 5) begin
			@(posedge clk_sys);
			#1 extra += (dt_discard === 1'b1);
		end
		check("discard repeat", 33'(extra), 33'h0);
		@(posedge clk_sys);
		dt_pending <= 0;
		cycles(2);
	endtask : discard

	// ------------------------------------------------------------
	// Result monitor
	// ------------------------------------------------------------
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			summarize();
		end
		if (psel && penable && pready && !pwrite)
			check("apb read", {pslverr, prdata}, rd_q.size() ? rd_q.pop_front() : 33'h0);
		if (cpu_retry_no_dt || cpu_accept_normal)
			check("cpu answer", {31'h0, cpu_retry_no_dt, cpu_accept_normal},
				cpu_q.size() ? cpu_q.pop_front() : 33'h0);
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		cycles(2);
		nrst <= 1;
		// Delayed transactions enabled before any retry enable write
		dt_enable <= 1;
		rd(ADDR_MISC_STATUS, 32'h0, 0);
		rd(ADDR_FAST_DMA0, 32'h0c, 0);
		rd(ADDR_FAST_DMA1, 32'h0c, 0);
		rd(ADDR_IOAPIC_BASE, 32'h0, 0);
		rd(ADDR_IRQ_STATUS, 32'h0, 0);
		rd(ADDR_IRQ_MASK, 32'h0, 0);
		wr(12'h004, 32'hffff_ffff);
		rd(12'h004, 32'h0, 1);
		wr(ADDR_MISC_STATUS, 32'hffff_ffff);
		rd(ADDR_MISC_STATUS, 32'h80, 0);
		check("dma enable reset", fast_dma_chan_en, 8'h00);
		// Reset relocation value first, then random values with the mask alternating
		r = 8'h00;
		for (int i = 0; i < 7; i++) begin
			if (i > 0) begin
				rnd = $random(seed);
				r = {rnd[7], i[0], rnd[5:0]};
				wr(ADDR_IOAPIC_BASE, {rnd[31:8], r});
				rd(ADDR_IOAPIC_BASE, {25'h0, r[6:0]}, 0);
			end
			base = {IOAPIC_WINDOW_HI, r[5:2], r[1:0], 10'h0};
			probe(base);
			probe(base | 32'h10);
			probe(base ^ 32'h1000);
			probe(base ^ 32'h400);
			probe(base ^ 32'h8000);
			probe(base | 32'h20);
			probe($random(seed));
		end
		wr(ADDR_FAST_DMA1, 32'h81);
		rd(ADDR_FAST_DMA1, 32'h89, 0);
		for (int c = 0; c < 8; c++) begin
			rnd = $random(seed);
			wr(ADDR_FAST_DMA0, {rnd[31:8], 1'b1, rnd[6:3], 3'(c)});
			rd(ADDR_FAST_DMA0, {24'h0, 5'h11, 3'(c)}, 0);
			exp = 8'h02;
			if (c != 4)
				exp[c] = 1'b1;
			check("dma enable", fast_dma_chan_en, exp);
		end
		wr(ADDR_FAST_DMA0, 32'h05);
		cycles(1);
		check("dma disable", fast_dma_chan_en, 8'h02);
		// Back-to-back processor cycles over every qualifier combination
		for (int en = 0; en < 2; en++) begin
			wr(ADDR_MISC_STATUS, 32'(en) << 7);
			for (int k = 0; k < 8; k++)
				cpu(k[0], k[1], !k[2], en[0]);
			cpu_cycle_valid <= 0;
			dt_pending <= 0;
			cycles(2);
		end
		check("irq masked", irq, 0);
		// Retries keep restarting the timer, so it never expires
		dt_enable <= 1;
		serr_on_timeout_enable <= 1;
		dt_pending <= 1;
		for (int k = 0; k < 2 * DCLK; k++) begin
			dt_retried <= (k % 5 == 0);
			@(posedge clk_sys);
			#1 check("discard with retries", dt_discard, 0);
		end
		@(posedge clk_sys);
		dt_retried <= 0;
		dt_pending <= 0;
		cycles(2);
		discard(0);
		rd(ADDR_MISC_STATUS, 32'h80, 0);
		discard(1);
		rd(ADDR_MISC_STATUS, 32'h8080, 0);
		apb(1, ADDR_MISC_STATUS, 32'h8080, 4'h1);
		rd(ADDR_MISC_STATUS, 32'h8080, 0);
		wr(ADDR_MISC_STATUS, 32'h0);
		rd(ADDR_MISC_STATUS, 32'h8000, 0);
		wr(ADDR_MISC_STATUS, 32'h8000);
		rd(ADDR_MISC_STATUS, 32'h0, 0);
		check("irq before mask", irq, 0);
		wr(ADDR_IRQ_MASK, 32'h2);
		rd(ADDR_IRQ_MASK, 32'h2, 0);
		check("irq unmasked", irq, 1);
		rd(ADDR_IRQ_STATUS, 32'h3, 0);
		cycles(1);
		check("irq cleared", irq, 0);
		rd(ADDR_IRQ_STATUS, 32'h0, 0);
		check("reads pending", 33'(rd_q.size() + cpu_q.size()), 33'h0);
		summarize();
	end
endmodule : bridge_misc_config_regs_tb
